// ===== hw/pcd_pkg.sv
// constants shared by the power calibration datapath
package pcd_pkg;

    // ************************************************************
    // register offsets on the plain register port
    // ************************************************************
    localparam logic [7:0] ADDR_POWER_GAIN_CHAN_A = 8'h05;
    localparam logic [7:0] ADDR_POWER_GAIN_CHAN_B = 8'h06;
    localparam logic [7:0] ADDR_PHASE_DELAY_CHAN_A = 8'h07;
    localparam logic [7:0] ADDR_PHASE_DELAY_CHAN_B = 8'h08;
    localparam logic [7:0] ADDR_REACTIVE_PHASE_TRIM = 8'h09;
    localparam logic [7:0] ADDR_ACTIVE_OFFSET_CHAN_A = 8'h0a;
    localparam logic [7:0] ADDR_ACTIVE_OFFSET_CHAN_B = 8'h0b;
    localparam logic [7:0] ADDR_REACTIVE_OFFSET_CHAN_A = 8'h0c;
    localparam logic [7:0] ADDR_REACTIVE_OFFSET_CHAN_B = 8'h0d;
    localparam logic [7:0] ADDR_METERING_CONTROL_TWO = 8'h17;
    // read-only views of the corrected results (upper halves)
    localparam logic [7:0] ADDR_RESULT_P_A = 8'h40;
    localparam logic [7:0] ADDR_RESULT_Q_A = 8'h41;
    localparam logic [7:0] ADDR_RESULT_P_B = 8'h42;
    localparam logic [7:0] ADDR_RESULT_Q_B = 8'h43;

    // ************************************************************
    // widths, fields and reset values
    // ************************************************************
    localparam int REG_W = 16;
    localparam int PHASE_W = 8;
    localparam int POWER_W = 32;
    localparam int SAMPLE_W = 16;
    localparam int HIST_DEPTH = 256;
    localparam int GAIN_FRAC = 15;
    localparam int PHASE_FINE_BIT_A = 8;
    localparam int PHASE_FINE_BIT_B = 9;
    // bits 15:14 and 11:10 are reserved and read back as zero
    localparam logic [15:0] CTL2_WRITE_MASK = 16'h33ff;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [7:0] PHASE_RESET = 8'h00;

    // ************************************************************
    // timing: sample step of the phase delay line
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int SAMPLE_RATE_KHZ = 895;
    // longest whole number of clocks inside one sample period
    localparam int SAMPLE_CYCLES =
        1000000 / (SAMPLE_RATE_KHZ * CLK_PERIOD_NS);
    localparam logic [7:0] SAMPLE_CNT_LAST = 8'(SAMPLE_CYCLES - 1);

endpackage : pcd_pkg

// ===== hw/pcd_calib.sv
// power calibration datapath: phase delay, gain, reactive trim, offsets
`timescale 1ns/10ps
`default_nettype none

module pcd_calib (
    input wire logic CLK, // core clock, 100 MHz
    input wire logic RESET_N, // synchronous reset, active low
    input wire logic [7:0] REG_ADDR, // register address
    input wire logic [15:0] REG_WDATA, // register write data
    input wire logic REG_WR, // write strobe
    input wire logic REG_RD, // read strobe
    output logic [15:0] REG_RDATA, // read data, cycle after strobe
    output logic SAMPLE_TICK, // one pulse per sample period
    input wire logic [15:0] CUR_A_IN, // current A sample
    input wire logic [15:0] CUR_B_IN, // current B sample
    input wire logic [15:0] VOLT_IN, // voltage sample
    output logic [15:0] CUR_A_ALIGNED, // delayed current A
    output logic [15:0] VOLT_A_ALIGNED, // voltage paired with A
    output logic [15:0] CUR_B_ALIGNED, // delayed current B
    output logic [15:0] VOLT_B_ALIGNED, // voltage paired with B
    input wire logic POWER_STB, // raw powers valid
    input wire logic [31:0] P_RAW_A, // uncorrected active, A
    input wire logic [31:0] Q_RAW_A, // uncorrected reactive, A
    input wire logic [31:0] P_RAW_B, // uncorrected active, B
    input wire logic [31:0] Q_RAW_B, // uncorrected reactive, B
    output logic [31:0] P_CAL_A, // corrected active, A
    output logic [31:0] Q_CAL_A, // corrected reactive, A
    output logic [31:0] P_CAL_B, // corrected active, B
    output logic [31:0] Q_CAL_B, // corrected reactive, B
    output logic POWER_VALID // corrected powers updated
);

    // ************************************************************
    // functions
    // ************************************************************

    // signed word times (1 + gain/2^15), kept to 32 bits
    function automatic logic [31:0] pcd_gain(
        input logic [31:0] x,
        input logic [15:0] g
    );
        logic signed [47:0] prod;
        prod = $signed(x) * $signed(g);
        return x + prod[46:15];
    endfunction : pcd_gain

    // q - trim * p / 2^15
    function automatic logic [31:0] pcd_trim(
        input logic [31:0] q,
        input logic [31:0] p,
        input logic [15:0] t
    );
        logic signed [47:0] prod;
        prod = $signed(t) * $signed(p);
        return q - prod[46:15];
    endfunction : pcd_trim

    // sign-extend a 16-bit calibration word to power width
    function automatic logic [31:0] pcd_sext(input logic [15:0] w);
        return {{16{w[15]}}, w};
    endfunction : pcd_sext

    // magnitude of the delay in half samples: {coarse, fine}
    function automatic logic [8:0] pcd_mag(
        input logic [7:0] phs,
        input logic fine
    );
        logic [8:0] d;
        d = {phs, fine};
        return d[8] ? 9'(-d) : d;
    endfunction : pcd_mag

    // a half step is the mean of two adjacent samples
    function automatic logic [15:0] pcd_pick(
        input logic [15:0] a,
        input logic [15:0] b,
        input logic half
    );
        logic [16:0] s;
        s = {a[15], a} + {b[15], b};
        return half ? s[16:1] : a;
    endfunction : pcd_pick

    // ************************************************************
    // calibration registers
    // ************************************************************
    logic [15:0] gain_a_reg;
    logic [15:0] gain_b_reg;
    logic [7:0] phase_a_reg;
    logic [7:0] phase_b_reg;
    logic [15:0] trim_reg;
    logic [15:0] apos_a_reg;
    logic [15:0] apos_b_reg;
    logic [15:0] rpos_a_reg;
    logic [15:0] rpos_b_reg;
    logic [15:0] ctl2_reg;

    // write decode
    wire wr_gain_a = REG_WR &&
        REG_ADDR == pcd_pkg::ADDR_POWER_GAIN_CHAN_A;
    wire wr_gain_b = REG_WR &&
        REG_ADDR == pcd_pkg::ADDR_POWER_GAIN_CHAN_B;
    wire wr_phase_a = REG_WR &&
        REG_ADDR == pcd_pkg::ADDR_PHASE_DELAY_CHAN_A;
    wire wr_phase_b = REG_WR &&
        REG_ADDR == pcd_pkg::ADDR_PHASE_DELAY_CHAN_B;
    wire wr_trim = REG_WR &&
        REG_ADDR == pcd_pkg::ADDR_REACTIVE_PHASE_TRIM;
    wire wr_apos_a = REG_WR &&
        REG_ADDR == pcd_pkg::ADDR_ACTIVE_OFFSET_CHAN_A;
    wire wr_apos_b = REG_WR &&
        REG_ADDR == pcd_pkg::ADDR_ACTIVE_OFFSET_CHAN_B;
    wire wr_rpos_a = REG_WR &&
        REG_ADDR == pcd_pkg::ADDR_REACTIVE_OFFSET_CHAN_A;
    wire wr_rpos_b = REG_WR &&
        REG_ADDR == pcd_pkg::ADDR_REACTIVE_OFFSET_CHAN_B;
    wire wr_ctl2 = REG_WR &&
        REG_ADDR == pcd_pkg::ADDR_METERING_CONTROL_TWO;

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            gain_a_reg <= pcd_pkg::REG_RESET;
            gain_b_reg <= pcd_pkg::REG_RESET;
            phase_a_reg <= pcd_pkg::PHASE_RESET;
            phase_b_reg <= pcd_pkg::PHASE_RESET;
            trim_reg <= pcd_pkg::REG_RESET;
            apos_a_reg <= pcd_pkg::REG_RESET;
            apos_b_reg <= pcd_pkg::REG_RESET;
            rpos_a_reg <= pcd_pkg::REG_RESET;
            rpos_b_reg <= pcd_pkg::REG_RESET;
            ctl2_reg <= pcd_pkg::REG_RESET;
        end else begin
            if (wr_gain_a) gain_a_reg <= REG_WDATA;
            if (wr_gain_b) gain_b_reg <= REG_WDATA;
            // phase words keep only their low byte
            if (wr_phase_a) phase_a_reg <= REG_WDATA[7:0];
            if (wr_phase_b) phase_b_reg <= REG_WDATA[7:0];
            if (wr_trim) trim_reg <= REG_WDATA;
            if (wr_apos_a) apos_a_reg <= REG_WDATA;
            if (wr_apos_b) apos_b_reg <= REG_WDATA;
            if (wr_rpos_a) rpos_a_reg <= REG_WDATA;
            if (wr_rpos_b) rpos_b_reg <= REG_WDATA;
            if (wr_ctl2) ctl2_reg <= REG_WDATA & pcd_pkg::CTL2_WRITE_MASK;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    logic [15:0] rdata_next;

    // unmapped addresses read as zero
    always_comb begin
        case (REG_ADDR)
            pcd_pkg::ADDR_POWER_GAIN_CHAN_A: rdata_next = gain_a_reg;
            pcd_pkg::ADDR_POWER_GAIN_CHAN_B: rdata_next = gain_b_reg;
            pcd_pkg::ADDR_PHASE_DELAY_CHAN_A:
                rdata_next = {8'h00, phase_a_reg};
            pcd_pkg::ADDR_PHASE_DELAY_CHAN_B:
                rdata_next = {8'h00, phase_b_reg};
            pcd_pkg::ADDR_REACTIVE_PHASE_TRIM: rdata_next = trim_reg;
            pcd_pkg::ADDR_ACTIVE_OFFSET_CHAN_A: rdata_next = apos_a_reg;
            pcd_pkg::ADDR_ACTIVE_OFFSET_CHAN_B: rdata_next = apos_b_reg;
            pcd_pkg::ADDR_REACTIVE_OFFSET_CHAN_A: rdata_next = rpos_a_reg;
            pcd_pkg::ADDR_REACTIVE_OFFSET_CHAN_B: rdata_next = rpos_b_reg;
            pcd_pkg::ADDR_METERING_CONTROL_TWO: rdata_next = ctl2_reg;
            pcd_pkg::ADDR_RESULT_P_A: rdata_next = P_CAL_A[31:16];
            pcd_pkg::ADDR_RESULT_Q_A: rdata_next = Q_CAL_A[31:16];
            pcd_pkg::ADDR_RESULT_P_B: rdata_next = P_CAL_B[31:16];
            pcd_pkg::ADDR_RESULT_Q_B: rdata_next = Q_CAL_B[31:16];
            default: rdata_next = 16'h0000;
        endcase
    end

    // data stand for one cycle only, zero otherwise
    always_ff @(posedge CLK) begin
        if (!RESET_N) REG_RDATA <= 16'h0000;
        else REG_RDATA <= REG_RD ? rdata_next : 16'h0000;
    end

    // ************************************************************
    // sample tick at the delay-line rate
    // ************************************************************
    logic [7:0] tick_cnt_reg;
    wire tick_now = (tick_cnt_reg == pcd_pkg::SAMPLE_CNT_LAST);

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            tick_cnt_reg <= 8'h00;
            SAMPLE_TICK <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_now ? 8'h00 : tick_cnt_reg + 8'h01;
            SAMPLE_TICK <= tick_now;
        end
    end

    // ************************************************************
    // sample history, newest at wp_reg
    // ************************************************************
    logic [15:0] hist_ia [0:pcd_pkg::HIST_DEPTH-1];
    logic [15:0] hist_ib [0:pcd_pkg::HIST_DEPTH-1];
    logic [15:0] hist_u [0:pcd_pkg::HIST_DEPTH-1];
    logic [7:0] wp_reg;
    wire [7:0] wp_next = wp_reg + 8'h01;

    // samples are taken in the cycle that SAMPLE_TICK is high
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            wp_reg <= 8'h00;
            for (int i = 0; i < pcd_pkg::HIST_DEPTH; i++) begin
                hist_ia[i] <= 16'h0000;
                hist_ib[i] <= 16'h0000;
                hist_u[i] <= 16'h0000;
            end
        end else if (SAMPLE_TICK) begin
            wp_reg <= wp_next;
            hist_ia[wp_next] <= CUR_A_IN;
            hist_ib[wp_next] <= CUR_B_IN;
            hist_u[wp_next] <= VOLT_IN;
        end
    end

    // ************************************************************
    // delay selection per channel
    // ************************************************************
    // signed coarse word plus fine bit
    wire fine_a = ctl2_reg[pcd_pkg::PHASE_FINE_BIT_A];
    wire fine_b = ctl2_reg[pcd_pkg::PHASE_FINE_BIT_B];
    wire [8:0] mag_a = pcd_mag(phase_a_reg, fine_a);
    wire [8:0] mag_b = pcd_mag(phase_b_reg, fine_b);
    // positive delays the current, negative the voltage
    wire neg_a = phase_a_reg[7];
    wire neg_b = phase_b_reg[7];

    // full range of 128 samples, half steps via fine bit
    wire [7:0] kc_a = neg_a ? 8'h00 : mag_a[8:1];
    wire [7:0] kv_a = neg_a ? mag_a[8:1] : 8'h00;
    wire [7:0] kc_b = neg_b ? 8'h00 : mag_b[8:1];
    wire [7:0] kv_b = neg_b ? mag_b[8:1] : 8'h00;
    wire hc_a = !neg_a && mag_a[0];
    wire hv_a = neg_a && mag_a[0];
    wire hc_b = !neg_b && mag_b[0];
    wire hv_b = neg_b && mag_b[0];

    // history addresses, wrapping round the ring
    wire [7:0] ic_a0 = wp_reg - kc_a;
    wire [7:0] ic_a1 = ic_a0 - 8'h01;
    wire [7:0] iv_a0 = wp_reg - kv_a;
    wire [7:0] iv_a1 = iv_a0 - 8'h01;
    wire [7:0] ic_b0 = wp_reg - kc_b;
    wire [7:0] ic_b1 = ic_b0 - 8'h01;
    wire [7:0] iv_b0 = wp_reg - kv_b;
    wire [7:0] iv_b1 = iv_b0 - 8'h01;

    // each channel has its own delay pair
    wire [15:0] cur_a_sel = pcd_pick(hist_ia[ic_a0], hist_ia[ic_a1], hc_a);
    wire [15:0] volt_a_sel = pcd_pick(hist_u[iv_a0], hist_u[iv_a1], hv_a);
    wire [15:0] cur_b_sel = pcd_pick(hist_ib[ic_b0], hist_ib[ic_b1], hc_b);
    wire [15:0] volt_b_sel = pcd_pick(hist_u[iv_b0], hist_u[iv_b1], hv_b);

    // registered so the outputs come straight from flops
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            CUR_A_ALIGNED <= 16'h0000;
            VOLT_A_ALIGNED <= 16'h0000;
            CUR_B_ALIGNED <= 16'h0000;
            VOLT_B_ALIGNED <= 16'h0000;
        end else begin
            CUR_A_ALIGNED <= cur_a_sel;
            VOLT_A_ALIGNED <= volt_a_sel;
            CUR_B_ALIGNED <= cur_b_sel;
            VOLT_B_ALIGNED <= volt_b_sel;
        end
    end

    // ************************************************************
    // power correction pipeline: gain, then trim and offsets
    // ************************************************************
    logic [31:0] p1_a_reg;
    logic [31:0] q1_a_reg;
    logic [31:0] p1_b_reg;
    logic [31:0] q1_b_reg;
    logic stage1_reg;

    // signed gain on active and reactive
    wire [31:0] p1_a_next = pcd_gain(P_RAW_A, gain_a_reg);
    wire [31:0] q1_a_next = pcd_gain(Q_RAW_A, gain_a_reg);
    wire [31:0] p1_b_next = pcd_gain(P_RAW_B, gain_b_reg);
    wire [31:0] q1_b_next = pcd_gain(Q_RAW_B, gain_b_reg);

    // stage one holds gain-corrected values
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            p1_a_reg <= 32'h00000000;
            q1_a_reg <= 32'h00000000;
            p1_b_reg <= 32'h00000000;
            q1_b_reg <= 32'h00000000;
            stage1_reg <= 1'b0;
        end else begin
            stage1_reg <= POWER_STB;
            if (POWER_STB) begin
                p1_a_reg <= p1_a_next;
                q1_a_reg <= q1_a_next;
                p1_b_reg <= p1_b_next;
                q1_b_reg <= q1_b_next;
            end
        end
    end

    // trim uses active power after gain
    wire [31:0] q2_a = pcd_trim(q1_a_reg, p1_a_reg, trim_reg);
    wire [31:0] q2_b = pcd_trim(q1_b_reg, p1_b_reg, trim_reg);

    wire [31:0] p_cal_a_next = p1_a_reg + pcd_sext(apos_a_reg);
    wire [31:0] p_cal_b_next = p1_b_reg + pcd_sext(apos_b_reg);
    wire [31:0] q_cal_a_next = q2_a + pcd_sext(rpos_a_reg);
    wire [31:0] q_cal_b_next = q2_b + pcd_sext(rpos_b_reg);

    // results hold until the next set; sums wrap, no saturation
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            P_CAL_A <= 32'h00000000;
            Q_CAL_A <= 32'h00000000;
            P_CAL_B <= 32'h00000000;
            Q_CAL_B <= 32'h00000000;
            POWER_VALID <= 1'b0;
        end else begin
            POWER_VALID <= stage1_reg;
            if (stage1_reg) begin
                P_CAL_A <= p_cal_a_next;
                Q_CAL_A <= q_cal_a_next;
                P_CAL_B <= p_cal_b_next;
                Q_CAL_B <= q_cal_b_next;
            end
        end
    end

endmodule : pcd_calib

`default_nettype wire

// ===== verification/pcd_calib_assertions.sv
// port-level assertion checker for the calibration datapath
`timescale 1ns/10ps
`default_nettype none

module pcd_calib_checker (
    input wire logic CLK, // core clock
    input wire logic RESET_N, // sync reset, low
    input wire logic [7:0] REG_ADDR, // register address
    input wire logic [15:0] REG_WDATA, // write data
    input wire logic REG_WR, // write strobe
    input wire logic REG_RD, // read strobe
    input wire logic [15:0] REG_RDATA, // read data
    input wire logic SAMPLE_TICK, // sample step pulse
    input wire logic POWER_STB, // raw powers valid
    input wire logic POWER_VALID, // results updated
    input wire logic [31:0] P_CAL_A, // corrected active A
    input wire logic [31:0] Q_CAL_B // corrected reactive B
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    // ************************************************************
    // properties
    // ************************************************************
    // write then read of the gain word gives all 16 bits back
    property p_gain_word;
        REG_RD && REG_ADDR == pcd_pkg::ADDR_POWER_GAIN_CHAN_A && $past(REG_WR)
            && $past(REG_ADDR) == REG_ADDR
            |=> REG_RDATA == $past(REG_WDATA, 2);
    endproperty
    a_gain_word: assert property (p_gain_word)
        else $error("gain word readback wrong");
    // phase word is only eight bits wide
    property p_phase_width;
        REG_RD && REG_ADDR == pcd_pkg::ADDR_PHASE_DELAY_CHAN_A
            |=> REG_RDATA[15:8] == 8'h00;
    endproperty
    a_phase_width: assert property (p_phase_width)
        else $error("phase word wider than eight bits");
    // one step per 111 clocks; the 8 clocks after each step hold no early tick
    property p_tick_period;
        SAMPLE_TICK |-> ##111 SAMPLE_TICK;
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("sample step period wrong");
    property p_tick_quiet;
        SAMPLE_TICK |=> !SAMPLE_TICK [*8];
    endproperty
    a_tick_quiet: assert property (p_tick_quiet)
        else $error("sample step too soon");
    property p_valid_lat;
        POWER_STB |-> ##2 POWER_VALID;
    endproperty
    a_valid_lat: assert property (p_valid_lat)
        else $error("corrected powers late");
    property p_valid_cause;
        POWER_VALID |-> $past(POWER_STB, 2);
    endproperty
    a_valid_cause: assert property (p_valid_cause)
        else $error("corrected powers without raw input");
    // results only move with the valid pulse
    property p_cal_hold;
        !POWER_VALID |-> $stable(P_CAL_A) && $stable(Q_CAL_B);
    endproperty
    a_cal_hold: assert property (p_cal_hold)
        else $error("corrected power moved while idle");
    property p_reset_out;
        $rose(RESET_N) |-> P_CAL_A == 32'h0 && !POWER_VALID && !SAMPLE_TICK;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs not clear after reset");
endmodule : pcd_calib_checker

bind pcd_calib pcd_calib_checker u_checker (
    .CLK(CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .SAMPLE_TICK(SAMPLE_TICK),
    .POWER_STB(POWER_STB), .POWER_VALID(POWER_VALID),
    .P_CAL_A(P_CAL_A), .Q_CAL_B(Q_CAL_B)
);
`default_nettype wire

// ===== verification/pcd_host.sv
// host model driving the calibration register port
`timescale 1ns/10ps
`default_nettype none

module pcd_host (
    input wire logic clk, // core clock
    output logic [7:0] addr, // register address
    output logic [15:0] wdata, // write data
    output logic wr, // write strobe
    output logic rd, // read strobe
    input wire logic [15:0] rdata // read data
);
    // ************************************************************
    // bus cycles, launched just after a rising edge
    // ************************************************************
    // idle bus from time zero
    initial begin
        addr = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end

    // one-cycle write, taken at the next edge
    task automatic write(input logic [7:0] a, input logic [15:0] d);
        // a write straight after a write lets one edge pass first, so
        // the strobe is never lowered and raised in the same step
        if (wr) @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : write

    // data stand only in the cycle after the strobe
    task automatic read(input logic [7:0] a, output logic [15:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : read
endmodule : pcd_host
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the power calibration datapath
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("unexpected %s exp %h got %h", nm, e, g); \
    end \
end

module tb;
    logic CLK;
    logic RESET_N;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic wr;
    logic rd;
    logic tick;
    logic stb;
    logic vld;
    logic [15:0] ca;
    logic [15:0] cb;
    logic [15:0] vv;
    logic [15:0] al [4];
    logic [31:0] raw [4];
    logic [31:0] cal [4];
    logic [15:0] cfg [9];
    logic [15:0] ha [8];
    logic [15:0] hb [8];
    logic [15:0] hv [8];
    int mismatches;
    int n_checks;

    pcd_calib dut (
        .CLK(CLK), .RESET_N(RESET_N), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SAMPLE_TICK(tick),
        .CUR_A_IN(ca), .CUR_B_IN(cb), .VOLT_IN(vv),
        .CUR_A_ALIGNED(al[0]), .VOLT_A_ALIGNED(al[1]),
        .CUR_B_ALIGNED(al[2]), .VOLT_B_ALIGNED(al[3]),
        .POWER_STB(stb), .P_RAW_A(raw[0]), .Q_RAW_A(raw[1]),
        .P_RAW_B(raw[2]), .Q_RAW_B(raw[3]), .P_CAL_A(cal[0]),
        .Q_CAL_A(cal[1]), .P_CAL_B(cal[2]), .Q_CAL_B(cal[3]),
        .POWER_VALID(vld)
    );
    pcd_host host (
        .clk(CLK), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    // free-running core clock
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // signed word times a fraction of 2^15, wrapped to 32 bits
    function automatic logic [31:0] frac(logic [31:0] x, logic [15:0] g);
        logic signed [63:0] m;
        m = $signed(x) * $signed(g);
        return m[46:15];
    endfunction : frac

    // half-step delay from the history; even steps are exact samples
    function automatic logic [15:0] pick(logic [15:0] h [8], int k, int d);
        logic [16:0] s;
        s = {h[k - (d + 1) / 2][15], h[k - (d + 1) / 2]}
            + {h[k - d / 2][15], h[k - d / 2]};
        return s[16:1];
    endfunction : pick

    // gain, trim and offsets of channel c, in that order
    task automatic exp_pq(input logic [31:0] p0, input logic [31:0] q0,
        input int c, output logic [31:0] p, output logic [31:0] q);
        logic [31:0] p1;
        logic [31:0] q1;
        p1 = p0 + frac(p0, cfg[c]);
        q1 = q0 + frac(q0, cfg[c]);
        p = p1 + {{16{cfg[5 + c][15]}}, cfg[5 + c]};
        q = q1 - frac(p1, cfg[4]) + {{16{cfg[7 + c][15]}}, cfg[7 + c]};
    endtask : exp_pq

    // one raw power set in, corrected set checked two cycles on
    task automatic pw(input logic [31:0] p, input logic [31:0] q);
        logic [31:0] e [4];
        exp_pq(p, q, 0, e[0], e[1]);
        exp_pq(q, p, 1, e[2], e[3]);
        raw[0] <= p;
        raw[1] <= q;
        raw[2] <= q;
        raw[3] <= p;
        stb <= 1'b1;
        @(posedge CLK);
        stb <= 1'b0;
        @(posedge CLK);
        @(negedge CLK);
        `CHK("valid", 1'b1, vld)
        for (int k = 0; k < 4; k++) begin
            `CHK("power", e[k], cal[k])
        end
        @(posedge CLK);
        // read-only result views carry the upper halves
        for (int k = 0; k < 4; k++) begin
            rchk(pcd_pkg::ADDR_RESULT_P_A + 8'(k), e[k][31:16]);
        end
    endtask : pw

    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        host.read(a, d);
        `CHK("rdata", e, d)
    endtask : rchk

    // bounded wait; returns just after the edge that raised the tick
    task automatic wait_tick();
        int n;
        n = 0;
        do begin
            @(posedge CLK);
            #1;
            n++;
        end while (tick !== 1'b1 && n < 200);
        `CHK("tick", 1'b1, tick)
    endtask : wait_tick

    // stream eight samples and compare the aligned pairs
    task automatic ph(input logic [7:0] pa, input logic [7:0] pb,
        input logic [15:0] ctl);
        int da;
        int db;
        da = int'($signed({pa, ctl[8]}));
        db = int'($signed({pb, ctl[9]}));
        host.write(pcd_pkg::ADDR_PHASE_DELAY_CHAN_A, {8'h00, pa});
        host.write(pcd_pkg::ADDR_PHASE_DELAY_CHAN_B, {8'h00, pb});
        host.write(pcd_pkg::ADDR_METERING_CONTROL_TWO, ctl);
        for (int k = 0; k < 8; k++) begin
            ha[k] = 16'(k) * 16'h0123;
            hb[k] = 16'(k) * 16'h0231;
            hv[k] = 16'(k) * 16'h0312;
            ca <= ha[k];
            cb <= hb[k];
            vv <= hv[k];
            wait_tick();
            @(posedge CLK);
            @(posedge CLK);
            @(negedge CLK);
            if (k >= 2) begin
                `CHK("cur_a", pick(ha, k, da > 0 ? da : 0), al[0])
                `CHK("volt_a", pick(hv, k, da < 0 ? -da : 0), al[1])
                `CHK("cur_b", pick(hb, k, db > 0 ? db : 0), al[2])
                `CHK("volt_b", pick(hv, k, db < 0 ? -db : 0), al[3])
            end
            @(posedge CLK);
        end
    endtask : ph

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // watchdog, far beyond the few thousand clocks the run needs
    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        RESET_N = 1'b0;
        stb = 1'b0;
        ca = 16'h0000;
        cb = 16'h0000;
        vv = 16'h0000;
        raw = '{32'h0, 32'h0, 32'h0, 32'h0};
        mismatches = 0;
        n_checks = 0;
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        @(posedge CLK);
        // cleared words: powers pass through untouched
        for (int i = 0; i < 9; i++) begin
            cfg[i] = 16'h0000;
            rchk(pcd_pkg::ADDR_POWER_GAIN_CHAN_A + 8'(i), 16'h0000);
        end
        rchk(pcd_pkg::ADDR_METERING_CONTROL_TWO, 16'h0000);
        pw(32'h7fff_0001, 32'h8000_1234);
        // all ones back to back; phase words keep eight bits
        for (int i = 0; i < 9; i++) begin
            host.write(pcd_pkg::ADDR_POWER_GAIN_CHAN_A + 8'(i), 16'hffff);
            rchk(pcd_pkg::ADDR_POWER_GAIN_CHAN_A + 8'(i),
                (i == 2 || i == 3) ? 16'h00ff : 16'hffff);
        end
        host.write(pcd_pkg::ADDR_METERING_CONTROL_TWO, 16'hffff);
        rchk(pcd_pkg::ADDR_METERING_CONTROL_TWO, 16'h33ff);
        host.write(8'h00, 16'hffff);
        rchk(8'h00, 16'h0000);
        // half gain on A, full negative gain on B, signed offsets
        cfg = '{16'h4000, 16'h8000, 16'h0000, 16'h0000, 16'h0800,
            16'hfff0, 16'h0010, 16'h0020, 16'h8001};
        for (int i = 0; i < 9; i++) begin
            host.write(pcd_pkg::ADDR_POWER_GAIN_CHAN_A + 8'(i), cfg[i]);
        end
        pw(32'h0012_3456, 32'hffed_cba0);
        pw(32'h8000_0000, 32'h7fff_ffff);
        // whole steps both signs, then half steps from the fine bits
        ph(8'h01, 8'hff, 16'h0000);
        ph(8'h00, 8'h01, 16'h0300);
        // second reset in mid-run clears the words again
        RESET_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        @(posedge CLK);
        rchk(pcd_pkg::ADDR_POWER_GAIN_CHAN_B, 16'h0000);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
